// *** timer16_capture_pulse_gen_test.sv ***
// self-checking bench for the 16-bit capture and pulse timer
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_pulse_gen_test;
  import tmr16_pkg::*;
  localparam logic [7:0] CL = TMR16_IDX_CTRL_LOW;
  localparam logic [7:0] CH = TMR16_IDX_CTRL_HIGH;
  localparam logic [7:0] PL = TMR16_IDX_PERIOD_LOW;
  localparam logic [7:0] DL = TMR16_IDX_DUTY_LOW;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic otherMatch = 1'b0;
  logic runOther = 1'b0;
  logic intAck = 1'b0;
  logic [1:0] edgeSel = 2'h0;
  logic fire = 1'b0;
  logic irq, tgl, pwm, pin;
  int pwmHigh, tglEdges;
  int fail_count = 0;
  int samples_checked = 0;
  int cycNo = 0;
  int irqSeen = 0;
  initial
    forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycNo <= cycNo + 1;
    irqSeen <= irqSeen + int'(irq === 1'b1);
    otherMatch <= runOther & ~otherMatch;
  end
  tmr16_timer dut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o_q(rdat),
    .wb_ack_o_q(ack), .otherTimerMatch(otherMatch), .intAck(intAck),
    .extIntPolarity(edgeSel), .timerIrq_q(irq), .captureTrigger(pin),
    .toggleOut_q(tgl), .pwmOut_q(pwm));
  tmr16_pin_model pins (.clk_sys(clk_sys), .fire(fire), .captureTrigger(pin),
    .pwmOut(pwm), .toggleOut(tgl), .pwmHigh(pwmHigh), .toggleEdges(tglEdges));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= {2'b00, idx, 2'b00};
    wdat <= {24'h0, d};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_sys);
      if (ack === 1'b1)
        break;
    end
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    if (n == 20)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, q);
    check(q, exp);
  endtask
  task automatic rd16(input logic [7:0] idx, output logic [15:0] v);
    logic [31:0] lo, hi;
    wb(1'b0, idx, 8'h00, lo);
    wb(1'b0, idx + 8'h01, 8'h00, hi);
    v = {hi[7:0], lo[7:0]};
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic setup(input logic [15:0] per, input logic [15:0] duty, input logic [7:0] cl);
    wr(CH, 8'h00);
    wr(PL, per[7:0]);
    wr(PL + 8'h01, per[15:8]);
    wr(DL, duty[7:0]);
    wr(DL + 8'h01, duty[15:8]);
    wr(CL, cl);
  endtask
  task automatic t_reset();
    int i;
    rd(CL, 32'h0);
    rd(CH, 32'h0);
    for (i = 4; i < 8; i++)
      rd(8'hc0 + 8'(i), 32'hff);
    wr(8'h10, 8'h55);
    rd(8'h10, 32'h0);
    check(pwm, 1'b0);
  endtask
  task automatic t_pwm(input logic pol);
    int h0, i0;
    setup(16'h0009, 16'h0003, {TMR16_CK_DIV1, 2'b00, pol, 2'b00});
    wr(CH, 8'hb0);
    waitc(30);
    h0 = pwmHigh;
    i0 = irqSeen;
    waitc(40);
    check(32'(pwmHigh - h0), pol ? 32'h1c : 32'h0c);
    check(32'(irqSeen - i0), 32'h4);
    wr(CH, 8'h30);
    i0 = irqSeen;
    waitc(30);
    check(32'(irqSeen - i0), 32'h0);
    check(pwm, pol);
    rd(CL, {24'h0, TMR16_CK_DIV1, 2'b10, pol, 2'b00});
    @(posedge clk_sys) intAck <= 1'b1;
    @(posedge clk_sys) intAck <= 1'b0;
    rd(CL, {24'h0, TMR16_CK_DIV1, 2'b00, pol, 2'b00});
  endtask
  task automatic t_oneshot();
    int i0, n, h0;
    logic [31:0] q;
    setup(16'h0009, 16'h0003, 8'hc0);
    i0 = irqSeen;
    wr(CH, 8'ha0);
    h0 = pwmHigh;
    for (n = 0; n < 30; n++)
    begin
      wb(1'b0, CH, 8'h00, q);
      if (q[7] === 1'b0)
        break;
    end
    check(q, 32'h20);
    waitc(40);
    check(32'(irqSeen - i0), 32'h1);
    check(32'(pwmHigh - h0), 32'h3);
    check(pwm, 1'b0);
  endtask
  task automatic t_capture();
    int e, p, t0;
    logic [15:0] v;
    setup(16'hffff, 16'h0000, 8'hc0);
    edgeSel <= TMR16_EDGE_NONE;
    wr(CH, 8'h90);
    e = cycNo;
    t0 = tglEdges;
    waitc(40);
    @(posedge clk_sys) fire <= 1'b1;
    @(posedge clk_sys) fire <= 1'b0;
    waitc(15);
    rd16(DL, v);
    check(v, 16'h0000);
    edgeSel <= TMR16_EDGE_RISE;
    @(posedge clk_sys) fire <= 1'b1;
    p = cycNo;
    @(posedge clk_sys) fire <= 1'b0;
    waitc(15);
    rd16(DL, v);
    check(int'(v) >= p - e + 2 && int'(v) <= p - e + 6, 1'b1);
    edgeSel <= TMR16_EDGE_FALL;
    @(posedge clk_sys) fire <= 1'b1;
    p = cycNo;
    @(posedge clk_sys) fire <= 1'b0;
    waitc(15);
    rd16(DL, v);
    check(int'(v) >= p - e + 8 && int'(v) <= p - e + 12, 1'b1);
    check(32'(tglEdges - t0), 32'h0);
    check(tgl, 1'b0);
  endtask
  task automatic t_timer();
    int divs[8] = '{512, 128, 32, 8, 4, 2, 1, 2};
    int s, i0, t0;
    setup(16'h0003, 16'h0001, 8'h00);
    for (s = 0; s < 8; s++)
    begin
      runOther <= (s == 7);
      wr(CL, {3'(s), 5'h00});
      wr(CH, 8'h80);
      waitc(16 * divs[s]);
      i0 = irqSeen;
      t0 = tglEdges;
      waitc(16 * divs[s]);
      check(32'(irqSeen - i0), 32'h4);
      check(32'(tglEdges - t0), 32'h4);
      wr(CH, 8'h00);
    end
    runOther <= 1'b0;
  endtask
  task automatic t_count();
    logic [15:0] a, b;
    setup(16'hffff, 16'h0000, 8'hc0);
    wr(CH, 8'h80);
    waitc(100);
    wr(CH, 8'h00);
    wr(CL, 8'hc1);
    rd16(DL, a);
    check(a >= 16'd90, 1'b1);
    waitc(50);
    wr(CL, 8'hc1);
    rd16(DL, b);
    check(b, a);
    wr(CH, 8'h01);
    rd(CH, 32'h0);
    wr(CL, 8'hc1);
    rd(CL, 32'hc0);
    rd16(DL, b);
    check(b, 16'h0000);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_pwm(1'b0);
    t_pwm(1'b1);
    t_oneshot();
    t_capture();
    t_timer();
    t_count();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** tmr16_pin_model.sv ***
// far-side model: capture trigger source and output pin observer
`timescale 1ns/1ps
`default_nettype none
module tmr16_pin_model (
  // clock and bench request
  input wire logic clk_sys,
  input wire logic fire,
  // pins
  output logic captureTrigger,
  input wire logic pwmOut,
  input wire logic toggleOut,
  // running tallies
  output int pwmHigh,
  output int toggleEdges
);
  logic [2:0] hold = 3'h0;
  logic lastTgl = 1'b0;
  logic trig = 1'b0;
  int highs = 0;
  int edges = 0;
  assign captureTrigger = trig;
  assign pwmHigh = highs;
  assign toggleEdges = edges;
  // pin is an input to the timer; model drives a clean pulse
  always @(posedge clk_sys)
  begin
    hold <= fire ? 3'h6 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
    trig <= fire || hold > 3'h1;
    highs <= highs + int'(pwmOut === 1'b1);
    edges <= edges + int'(toggleOut !== lastTgl);
    lastTgl <= toggleOut;
  end
endmodule
`default_nettype wire

// *** tmr16_pkg.sv ***
// constants for the 16-bit capture and pulse generation timer
package tmr16_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] TMR16_IDX_CTRL_LOW = 8'hc2;
  localparam logic [7:0] TMR16_IDX_CTRL_HIGH = 8'hc3;
  localparam logic [7:0] TMR16_IDX_PERIOD_LOW = 8'hc4;
  localparam logic [7:0] TMR16_IDX_PERIOD_HIGH = 8'hc5;
  localparam logic [7:0] TMR16_IDX_DUTY_LOW = 8'hc6;
  localparam logic [7:0] TMR16_IDX_DUTY_HIGH = 8'hc7;
  // reset values
  localparam logic [7:0] TMR16_RST_CTRL = 8'h00;
  localparam logic [7:0] TMR16_RST_DATA = 8'hff;
  // control high fields
  localparam int TMR16_BIT_ENABLE = 7;
  localparam int TMR16_BIT_MODE_HI = 5;
  localparam int TMR16_BIT_MODE_LO = 4;
  localparam int TMR16_BIT_CLEAR = 0;
  // control low fields
  localparam int TMR16_BIT_CKSEL_HI = 7;
  localparam int TMR16_BIT_CKSEL_LO = 5;
  localparam int TMR16_BIT_IRQFLAG = 4;
  localparam int TMR16_BIT_POLARITY = 2;
  localparam int TMR16_BIT_CNTREAD = 0;
  // operating modes
  localparam logic [1:0] TMR16_MODE_TIMER = 2'h0;
  localparam logic [1:0] TMR16_MODE_CAPTURE = 2'h1;
  localparam logic [1:0] TMR16_MODE_ONESHOT = 2'h2;
  localparam logic [1:0] TMR16_MODE_REPEAT = 2'h3;
  // clock selections
  localparam logic [2:0] TMR16_CK_DIV512 = 3'h0;
  localparam logic [2:0] TMR16_CK_DIV128 = 3'h1;
  localparam logic [2:0] TMR16_CK_DIV32 = 3'h2;
  localparam logic [2:0] TMR16_CK_DIV8 = 3'h3;
  localparam logic [2:0] TMR16_CK_DIV4 = 3'h4;
  localparam logic [2:0] TMR16_CK_DIV2 = 3'h5;
  localparam logic [2:0] TMR16_CK_DIV1 = 3'h6;
  localparam logic [2:0] TMR16_CK_OTHER = 3'h7;
  localparam int TMR16_PRESCALE_W = 9;
  // capture edge selection
  localparam logic [1:0] TMR16_EDGE_NONE = 2'h0;
  localparam logic [1:0] TMR16_EDGE_FALL = 2'h1;
  localparam logic [1:0] TMR16_EDGE_RISE = 2'h2;
  localparam logic [1:0] TMR16_EDGE_BOTH = 2'h3;
endpackage

// *** tmr16_timer.sv ***
// 16-bit timer with capture and pulse generation, classic wishbone slave
`timescale 1ns/1ps
`default_nettype none

module tmr16_timer
  import tmr16_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int ADR_W = 12
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o_q,
  output logic wb_ack_o_q,
  // system side
  input wire logic otherTimerMatch,
  input wire logic intAck,
  input wire logic [1:0] extIntPolarity,
  output logic timerIrq_q,
  // pins
  input wire logic captureTrigger,
  output logic toggleOut_q,
  output logic pwmOut_q
);

  logic [7:0] periodLow_q;
  logic [7:0] periodHigh_q;
  logic [7:0] dutyLow_q;
  logic [7:0] dutyHigh_q;
  logic enable_q;
  logic [1:0] mode_q;
  logic clearPend_q;
  logic [2:0] clkSel_q;
  logic irqFlag_q;
  logic polarity_q;
  logic readPend_q;
  logic startPend_q;
  logic [CNT_W-1:0] count_q;
  logic [TMR16_PRESCALE_W-1:0] prescale_q;
  logic trigS1_q;
  logic trigS2_q;
  logic trigS3_q;
  logic trigLvl_q;

  logic [CNT_W-1:0] periodVal;
  logic [CNT_W-1:0] dutyVal;
  logic wbReq;
  logic wbWrite;
  logic [ADR_W-3:0] wbIdx;
  logic selCtrlLow;
  logic selCtrlHigh;
  logic selPerLow;
  logic selPerHigh;
  logic selDutyLow;
  logic selDutyHigh;
  logic tick;
  logic match;
  logic isPpg;
  logic captureEv;
  logic trigRise;
  logic trigFall;
  logic startLevel;
  logic idleLevel;

  assign periodVal = {periodHigh_q, periodLow_q};
  assign dutyVal = {dutyHigh_q, dutyLow_q};
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o_q;
  assign wbWrite = wbReq && wb_we_i && wb_sel_i[0];
  assign wbIdx = wb_adr_i[ADR_W-1:2];
  assign selCtrlLow = wbIdx == (ADR_W-2)'(TMR16_IDX_CTRL_LOW);
  assign selCtrlHigh = wbIdx == (ADR_W-2)'(TMR16_IDX_CTRL_HIGH);
  assign selPerLow = wbIdx == (ADR_W-2)'(TMR16_IDX_PERIOD_LOW);
  assign selPerHigh = wbIdx == (ADR_W-2)'(TMR16_IDX_PERIOD_HIGH);
  assign selDutyLow = wbIdx == (ADR_W-2)'(TMR16_IDX_DUTY_LOW);
  assign selDutyHigh = wbIdx == (ADR_W-2)'(TMR16_IDX_DUTY_HIGH);
  assign isPpg = mode_q[1];
  assign startLevel = !polarity_q;
  assign idleLevel = polarity_q;

  // count clock selection
  always_comb
  begin
    case (clkSel_q)
      TMR16_CK_DIV512: tick = &prescale_q[8:0];
      TMR16_CK_DIV128: tick = &prescale_q[6:0];
      TMR16_CK_DIV32: tick = &prescale_q[4:0];
      TMR16_CK_DIV8: tick = &prescale_q[2:0];
      TMR16_CK_DIV4: tick = &prescale_q[1:0];
      TMR16_CK_DIV2: tick = prescale_q[0];
      TMR16_CK_DIV1: tick = 1'b1;
      TMR16_CK_OTHER: tick = otherTimerMatch;
      default: tick = 1'b0;
    endcase
  end

  assign match = enable_q && !startPend_q && tick && (count_q == periodVal);

  // capture edge, chosen by the external interrupt polarity
  assign trigRise = trigS2_q && trigS3_q && !trigLvl_q;
  assign trigFall = !trigS2_q && !trigS3_q && trigLvl_q;
  always_comb
  begin
    case (extIntPolarity)
      TMR16_EDGE_FALL: captureEv = trigFall;
      TMR16_EDGE_RISE: captureEv = trigRise;
      TMR16_EDGE_BOTH: captureEv = trigFall || trigRise;
      default: captureEv = 1'b0;
    endcase
  end

  // free-running prescaler
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      prescale_q <= '0;
    else
      prescale_q <= prescale_q + 1'b1;
  end

  // trigger pin synchroniser
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      trigS1_q <= 1'b0;
      trigS2_q <= 1'b0;
      trigS3_q <= 1'b0;
      trigLvl_q <= 1'b0;
    end
    else
    begin
      trigS1_q <= captureTrigger;
      trigS2_q <= trigS1_q;
      trigS3_q <= trigS2_q;
      if (trigS2_q == trigS3_q)
        trigLvl_q <= trigS3_q;
    end
  end

  // control high: enable, mode, clear request
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      enable_q <= TMR16_RST_CTRL[TMR16_BIT_ENABLE];
      mode_q <= TMR16_RST_CTRL[TMR16_BIT_MODE_HI:TMR16_BIT_MODE_LO];
      clearPend_q <= 1'b0;
      startPend_q <= 1'b0;
    end
    else
    begin
      clearPend_q <= 1'b0;
      startPend_q <= 1'b0;
      if (wbWrite && selCtrlHigh)
      begin
        enable_q <= wb_dat_i[TMR16_BIT_ENABLE];
        mode_q <= wb_dat_i[TMR16_BIT_MODE_HI:TMR16_BIT_MODE_LO];
        clearPend_q <= wb_dat_i[TMR16_BIT_CLEAR];
        startPend_q <= wb_dat_i[TMR16_BIT_ENABLE];
      end
      else if (match && mode_q == TMR16_MODE_ONESHOT)
        enable_q <= 1'b0;
    end
  end

  // control low: clock select, flag, polarity, read request
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      clkSel_q <= TMR16_RST_CTRL[TMR16_BIT_CKSEL_HI:TMR16_BIT_CKSEL_LO];
      irqFlag_q <= TMR16_RST_CTRL[TMR16_BIT_IRQFLAG];
      polarity_q <= TMR16_RST_CTRL[TMR16_BIT_POLARITY];
      readPend_q <= 1'b0;
    end
    else
    begin
      readPend_q <= 1'b0;
      if (wbWrite && selCtrlLow)
      begin
        clkSel_q <= wb_dat_i[TMR16_BIT_CKSEL_HI:TMR16_BIT_CKSEL_LO];
        polarity_q <= wb_dat_i[TMR16_BIT_POLARITY];
        readPend_q <= wb_dat_i[TMR16_BIT_CNTREAD];
      end
      // a new interrupt beats acknowledge or a software clear
      if (match)
        irqFlag_q <= 1'b1;
      else if (intAck || (wbWrite && selCtrlLow && !wb_dat_i[TMR16_BIT_IRQFLAG]))
        irqFlag_q <= 1'b0;
    end
  end

  // interrupt request pulse towards the system
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      timerIrq_q <= 1'b0;
    else
      timerIrq_q <= match;
  end

  // period data pair
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      periodLow_q <= TMR16_RST_DATA;
      periodHigh_q <= TMR16_RST_DATA;
    end
    else if (wbWrite && selPerLow)
      periodLow_q <= wb_dat_i[7:0];
    else if (wbWrite && selPerHigh)
      periodHigh_q <= wb_dat_i[7:0];
  end

  // duty / capture pair; hardware loads win over software writes
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dutyLow_q <= TMR16_RST_DATA;
      dutyHigh_q <= TMR16_RST_DATA;
    end
    else if ((captureEv && enable_q && mode_q == TMR16_MODE_CAPTURE) || readPend_q)
    begin
      {dutyHigh_q, dutyLow_q} <= count_q;
    end
    else if (wbWrite && selDutyLow)
      dutyLow_q <= wb_dat_i[7:0];
    else if (wbWrite && selDutyHigh)
      dutyHigh_q <= wb_dat_i[7:0];
  end

  // counter
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      count_q <= '0;
    else if (clearPend_q || startPend_q)
      count_q <= '0;
    else if (match)
      count_q <= '0;
    else if (enable_q && tick)
      count_q <= count_q + 1'b1;
  end

  // toggle pin: toggles on match in timer mode only
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      toggleOut_q <= 1'b0;
    else if (!enable_q || mode_q != TMR16_MODE_TIMER)
      toggleOut_q <= idleLevel;
    else if (startPend_q)
      toggleOut_q <= startLevel;
    else if (match)
      toggleOut_q <= !toggleOut_q;
  end

  // pwm pin: start level below duty, other level from duty to period
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      pwmOut_q <= 1'b0;
    // stay idle while the restart clears a stale count
    else if (!enable_q || !isPpg || startPend_q)
      pwmOut_q <= idleLevel;
    else if (count_q < dutyVal)
      pwmOut_q <= startLevel;
    else
      pwmOut_q <= !startLevel;
  end

  // bus answer: one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_o_q <= 1'b0;
      wb_dat_o_q <= '0;
    end
    else
    begin
      wb_ack_o_q <= wbReq;
      wb_dat_o_q <= '0;
      if (wbReq && !wb_we_i)
      begin
        if (selCtrlLow)
          wb_dat_o_q[7:0] <= {clkSel_q, irqFlag_q, 1'b0, polarity_q, 1'b0, readPend_q};
        else if (selCtrlHigh)
          wb_dat_o_q[7:0] <= {enable_q, 1'b0, mode_q, 3'h0, clearPend_q};
        else if (selPerLow)
          wb_dat_o_q[7:0] <= periodLow_q;
        else if (selPerHigh)
          wb_dat_o_q[7:0] <= periodHigh_q;
        else if (selDutyLow)
          wb_dat_o_q[7:0] <= dutyLow_q;
        else if (selDutyHigh)
          wb_dat_o_q[7:0] <= dutyHigh_q;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_capture_loads_duty: assert property (
    (captureEv && enable_q && mode_q == TMR16_MODE_CAPTURE && !readPend_q)
      |=> ({dutyHigh_q, dutyLow_q} == $past(count_q)))
    else $error("capture did not load the duty pair");

  a_match_clears_count: assert property (
    (match && !clearPend_q && !startPend_q) |=> (count_q == '0))
    else $error("counter not cleared on period match");

  a_match_sets_flag: assert property (
    match |=> (irqFlag_q && timerIrq_q))
    else $error("interrupt flag not set on match");

  a_oneshot_stops: assert property (
    (match && mode_q == TMR16_MODE_ONESHOT && !(wbWrite && selCtrlHigh)) |=> !enable_q)
    else $error("one-shot did not clear enable");

  a_capture_no_wave: assert property (
    (mode_q == TMR16_MODE_CAPTURE) [*2] |-> (toggleOut_q == polarity_q))
    else $error("toggle pin moved in capture mode");

  a_clear_self_ends: assert property (
    clearPend_q |=> (count_q == '0 && !clearPend_q))
    else $error("clear request did not clear counter");

  a_stopped_holds: assert property (
    (!enable_q && !clearPend_q && !startPend_q) |=> $stable(count_q))
    else $error("counter moved while disabled");

  a_start_clears: assert property (
    (wbWrite && selCtrlHigh && wb_dat_i[TMR16_BIT_ENABLE]) |-> ##2 (count_q == '0))
    else $error("enable write did not restart counter");

  a_pwm_idle_level: assert property (
    !enable_q |=> (pwmOut_q == $past(polarity_q)))
    else $error("pwm pin not at idle level");

  a_read_copies: assert property (
    readPend_q |=> ({dutyHigh_q, dutyLow_q} == $past(count_q)))
    else $error("counter read did not copy counter");

  a_ack_single: assert property (
    wb_ack_o_q |=> !wb_ack_o_q)
    else $error("bus ack longer than one cycle");

  c_capture_event: cover property (captureEv && enable_q && mode_q == TMR16_MODE_CAPTURE);
  c_oneshot_done: cover property (match && mode_q == TMR16_MODE_ONESHOT);
  c_repeat_period: cover property (match && mode_q == TMR16_MODE_REPEAT);
  c_counter_read: cover property (readPend_q && enable_q);

endmodule

`default_nettype wire
